/* odp_pkg.sv */
// package: constants and types for the divider pair control block
// What this block does
// - bypass bit 7 powers divider down and passes input clock; reset state is bypass
// - ignore-realign bit 6 at 0 obeys chip realign; at 1 ignores it entirely
// - force-level bit 5 acts only when ignore-realign is also set
// - while bypassed the force-level bit has no influence on the output
// - when forcing without a direct route, force-level 0 holds output low, 1 holds it high
// - start-polarity bit 4 picks the divided output's starting level, 0 low
// - 4-bit phase offset in bits 3:0, reset zero, sets coarse phase delay
// - direct-route bit 1 at 0 (default) drives both pair outputs from the divider
// - direct-route 1 with source select 10b sends oscillator straight to both outputs
// - direct-route 1 with source select 00b sends external clock to both outputs
// - with source select 01b the direct-route bit changes nothing
// - routing bit 0 at 1 disables duty-cycle correction; 0 keeps it on
// - 4-bit low count holds low input cycles minus one
// - 4-bit high count holds high input cycles minus one
package odp_pkg;

    // ****************************************
    // register indices (byte address = 4 * index)
    // ****************************************
    localparam logic [9:0]  ODP_IDX_COUNTS  = 10'h190;
    localparam logic [9:0]  ODP_IDX_MODE    = 10'h191;
    localparam logic [9:0]  ODP_IDX_ROUTING = 10'h192;
    localparam logic [9:0]  ODP_IDX_SRCSEL  = 10'h1e1;
    localparam logic [9:0]  ODP_IDX_STATUS  = 10'h1f0;
    localparam int          ODP_ADDR_W      = 12;

    // ****************************************
    // reset values and field positions
    // ****************************************
    localparam logic [7:0]  ODP_RST_COUNTS  = 8'h00;
    localparam logic [7:0]  ODP_RST_MODE    = 8'h80;
    localparam logic [7:0]  ODP_RST_ROUTING = 8'h00;
    localparam logic [1:0]  ODP_RST_SRCSEL  = 2'h0;
    localparam int          ODP_BIT_DIRECT  = 1;
    localparam int          ODP_BIT_DUTY_FIX_DISABLE  = 0;
    localparam logic [1:0]  ODP_SRC_EXT     = 2'h0;
    localparam logic [1:0]  ODP_SRC_NONE    = 2'h1;
    localparam logic [1:0]  ODP_SRC_OSC     = 2'h2;
    localparam logic [1:0]  ODP_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  ODP_RESP_SLVERR = 2'h2;

    // ****************************************
    // types
    // ****************************************
    typedef struct packed {
        logic       bypass;
        logic       ignore_realign;
        logic       force_high;
        logic       start_high;
        logic [3:0] phase;
    } odp_mode_s;

    typedef struct packed {
        logic [3:0] low_cnt;
        logic [3:0] high_cnt;
    } odp_counts_s;

    typedef enum logic [2:0] {
        ODP_ST_IDLE  = 3'b001,
        ODP_ST_DELAY = 3'b010,
        ODP_ST_RUN   = 3'b100
    } odp_state_e;

endpackage : odp_pkg

/* odp_top.sv */
// module: divider pair control with its AXI4-Lite register slave
`timescale 1ns/10ps
`default_nettype none
module odp_top
    import odp_pkg::*;
(
    // clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // axi4-lite write
    input  wire logic [ODP_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output var  logic                  s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output var  logic                  s_axi_wready,
    output var  logic [1:0]            s_axi_bresp,
    output var  logic                  s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // axi4-lite read
    input  wire logic [ODP_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output var  logic                  s_axi_arready,
    output var  logic [31:0]           s_axi_rdata,
    output var  logic [1:0]            s_axi_rresp,
    output var  logic                  s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // high-speed clock levels, sampled
    input  wire logic                  osc_level,
    input  wire logic                  ext_level,
    // chip-level realign request
    input  wire logic                  realign_req,
    // pair outputs and analog controls
    output var  logic                  pair_a_first_out,
    output var  logic                  pair_a_second_out,
    output var  logic                  div_power_down,
    output var  logic                  duty_fix_disable
);

    // ****************************************
    // register file
    // ****************************************
    logic [7:0]  counts_reg;
    logic [7:0]  mode_reg;
    logic [7:0]  routing_reg;
    logic [1:0]  srcsel_reg;
    odp_mode_s   mode;
    odp_counts_s cnts;
    assign mode = odp_mode_s'(mode_reg);
    assign cnts = odp_counts_s'(counts_reg);

    function automatic logic [1:0] map_hit(input logic [ODP_ADDR_W-1:0] a);
        logic [9:0] idx;
        idx = a[ODP_ADDR_W-1:2];
        map_hit = 2'b00;
        if (idx == ODP_IDX_COUNTS || idx == ODP_IDX_MODE || idx == ODP_IDX_ROUTING ||
            idx == ODP_IDX_SRCSEL) begin
            map_hit = 2'b11;
        end else if (idx == ODP_IDX_STATUS) begin
            map_hit = 2'b01;
        end
    endfunction : map_hit

    // write: both channels taken together, so arrival order does not matter
    // ready-low term stops a second take while the master drops its valids
    wire        wr_go   = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
    wire [9:0]  wr_idx  = s_axi_awaddr[ODP_ADDR_W-1:2];
    wire [1:0]  wr_hit  = map_hit(s_axi_awaddr);
    wire        wr_ok   = wr_hit[1];
    wire        wr_lane = wr_go && s_axi_wstrb[0];
    wire [7:0]  wr_byte = s_axi_wdata[7:0];
    wire        mode_wr = wr_lane && wr_idx == ODP_IDX_MODE;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            counts_reg  <= ODP_RST_COUNTS;
            mode_reg    <= ODP_RST_MODE;
            routing_reg <= ODP_RST_ROUTING;
            srcsel_reg  <= ODP_RST_SRCSEL;
        end else begin
            if (wr_lane && wr_idx == ODP_IDX_COUNTS)  counts_reg  <= wr_byte;
            if (mode_wr)                              mode_reg    <= wr_byte;
            if (wr_lane && wr_idx == ODP_IDX_ROUTING) routing_reg <= wr_byte;
            if (wr_lane && wr_idx == ODP_IDX_SRCSEL)  srcsel_reg  <= wr_byte[1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= ODP_RESP_OKAY;
        end else begin
            s_axi_awready <= wr_go;
            s_axi_wready  <= wr_go;
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? ODP_RESP_OKAY : ODP_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ****************************************
    // read path
    // ****************************************
    odp_state_e st_reg;
    logic       div_lvl_reg;
    // one read in flight: a new address waits until rvalid clears
    wire        rd_go  = s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
    wire [9:0]  rd_idx = s_axi_araddr[ODP_ADDR_W-1:2];
    wire [7:0]  status = {4'h0, st_reg, div_lvl_reg};
    wire [7:0]  rd_byte = rd_idx == ODP_IDX_COUNTS  ? counts_reg  :
                          rd_idx == ODP_IDX_MODE    ? mode_reg    :
                          rd_idx == ODP_IDX_ROUTING ? routing_reg :
                          rd_idx == ODP_IDX_SRCSEL  ? {6'h00, srcsel_reg} :
                          rd_idx == ODP_IDX_STATUS  ? status      : 8'h00;
    wire        rd_ok  = map_hit(s_axi_araddr) != 2'b00;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= ODP_RESP_OKAY;
        end else begin
            s_axi_arready <= rd_go;
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h00_0000, rd_byte};
                s_axi_rresp  <= rd_ok ? ODP_RESP_OKAY : ODP_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ****************************************
    // divider input and routing decode
    // ****************************************
    // divider input follows the global source: oscillator on 10b, else external
    wire sel_level = srcsel_reg == ODP_SRC_OSC ? osc_level : ext_level;
    logic sel_prev_reg;
    // compare with the registered last level: one tick per rising edge of the selected level
    wire  tick      = sel_level && !sel_prev_reg;
    wire  direct    = routing_reg[ODP_BIT_DIRECT];
    wire  route_osc = direct && srcsel_reg == ODP_SRC_OSC;
    wire  route_ext = direct && srcsel_reg == ODP_SRC_EXT;
    wire  forcing   = mode.ignore_realign && !mode.bypass;
    // leaving bypass starts the divider as if realigned
    wire  accept    = !mode.bypass && (st_reg == ODP_ST_IDLE ||
                      (realign_req && !mode.ignore_realign));

    // ****************************************
    // divider state machine
    // ****************************************
    // realign held high re-arms every cycle, so the offset runs from its release
    odp_state_e st_next;
    logic [3:0] cnt_reg;
    logic [3:0] dly_reg;
    wire        expire = tick && cnt_reg == 4'h0;

    always_comb begin
        st_next = st_reg;
        case (st_reg)
            ODP_ST_IDLE:  st_next = accept ? ODP_ST_DELAY : ODP_ST_IDLE;
            ODP_ST_DELAY: st_next = (tick && dly_reg == 4'h0) ? ODP_ST_RUN : ODP_ST_DELAY;
            ODP_ST_RUN:   st_next = ODP_ST_RUN;
            default:      st_next = ODP_ST_IDLE;
        endcase
        if (mode.bypass) begin
            st_next = ODP_ST_IDLE;
        end else if (accept) begin
            st_next = ODP_ST_DELAY;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg       <= ODP_ST_IDLE;
            sel_prev_reg <= 1'b0;
            cnt_reg      <= 4'h0;
            dly_reg      <= 4'h0;
            div_lvl_reg  <= 1'b0;
        end else begin
            st_reg       <= st_next;
            sel_prev_reg <= sel_level;
            if (accept) begin
                dly_reg     <= mode.phase;
                div_lvl_reg <= mode.start_high;
                cnt_reg     <= mode.start_high ? cnts.high_cnt : cnts.low_cnt;
            end else if (st_reg == ODP_ST_DELAY && tick) begin
                dly_reg <= dly_reg - 4'h1;
            end else if (st_reg == ODP_ST_RUN && tick) begin
                if (expire) begin
                    div_lvl_reg <= !div_lvl_reg;
                    // low stretch ends: reload high count, and the reverse
                    cnt_reg     <= div_lvl_reg ? cnts.low_cnt : cnts.high_cnt;
                end else begin
                    cnt_reg <= cnt_reg - 4'h1;
                end
            end
        end
    end

    // ****************************************
    // output select
    // ****************************************
    // direct route outranks bypass: the pair then carries the raw source
    wire out_next = route_osc    ? osc_level        :
                    route_ext    ? ext_level        :
                    mode.bypass  ? sel_level        :
                    forcing      ? mode.force_high  :
                    div_lvl_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pair_a_first_out  <= 1'b0;
            pair_a_second_out <= 1'b0;
            div_power_down    <= 1'b1;
            duty_fix_disable  <= 1'b0;
        end else begin
            pair_a_first_out  <= out_next;
            pair_a_second_out <= out_next;
            div_power_down    <= mode.bypass;
            duty_fix_disable  <= routing_reg[ODP_BIT_DUTY_FIX_DISABLE];
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_accept;
        accept && !mode_wr;
    endsequence

    sequence s_armed;
        st_reg == ODP_ST_DELAY && dly_reg == $past(mode.phase);
    endsequence

    a_bypass_pass: assert property ((mode.bypass && !direct) |=>
        pair_a_first_out == $past(sel_level) && div_power_down)
        else $error("bypass does not pass input clock");
    a_realign_ignored: assert property ((st_reg == ODP_ST_RUN && mode.ignore_realign &&
        !mode.bypass && realign_req) |=> st_reg == ODP_ST_RUN)
        else $error("realign taken while ignored");
    a_force_gated: assert property ((!mode.ignore_realign && !mode.bypass && !direct) |=>
        pair_a_first_out == $past(div_lvl_reg))
        else $error("output forced without ignore-realign");
    a_force_level: assert property ((forcing && !direct) |=>
        pair_a_first_out == $past(mode.force_high) && pair_a_second_out == pair_a_first_out)
        else $error("forced level wrong");
    a_start_phase: assert property (s_accept |=> s_armed ##0
        div_lvl_reg == $past(mode.start_high))
        else $error("restart level or phase wrong");
    a_phase_hold: assert property ((st_reg == ODP_ST_DELAY && !tick && !accept &&
        !mode.bypass) |=> st_reg == ODP_ST_DELAY && $stable(div_lvl_reg))
        else $error("phase delay left early");
    a_route_osc: assert property (route_osc |=>
        pair_a_first_out == $past(osc_level) && pair_a_second_out == $past(osc_level))
        else $error("oscillator not routed");
    a_route_ext: assert property (route_ext |=>
        pair_a_first_out == $past(ext_level) && pair_a_second_out == $past(ext_level))
        else $error("external clock not routed");
    a_route_none: assert property ((direct && srcsel_reg == ODP_SRC_NONE && !mode.bypass &&
        !mode.ignore_realign) |=> pair_a_first_out == $past(div_lvl_reg))
        else $error("direct route acted on 01b");
    a_duty_fix: assert property (##1 duty_fix_disable == $past(routing_reg[ODP_BIT_DUTY_FIX_DISABLE]))
        else $error("duty fix flag mismatch");
    a_count_reload: assert property ((st_reg == ODP_ST_RUN && expire && !accept &&
        !mode.bypass) |=> div_lvl_reg != $past(div_lvl_reg) &&
        cnt_reg == ($past(div_lvl_reg) ? $past(cnts.low_cnt) : $past(cnts.high_cnt)))
        else $error("count reload wrong");

    // ****************************************
    // bus handshake checks
    // ****************************************
    sequence s_wr_taken;
        wr_go;
    endsequence

    sequence s_wr_answer;
        s_axi_awready && s_axi_wready && s_axi_bvalid;
    endsequence

    a_write_answer: assert property (s_wr_taken |=> s_wr_answer)
        else $error("write not answered in one cycle");
    a_write_resp: assert property (s_wr_taken |=>
        s_axi_bresp == ($past(wr_ok) ? ODP_RESP_OKAY : ODP_RESP_SLVERR))
        else $error("write response code wrong");
    a_mode_lands: assert property (mode_wr |=> mode_reg == $past(wr_byte))
        else $error("mode write lost");
    a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready && !s_axi_wready)
        else $error("write ready held too long");
    a_bvalid_hold: assert property ((s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
        else $error("write response dropped");
    a_read_answer: assert property (rd_go |=> s_axi_arready && s_axi_rvalid &&
        s_axi_rdata == {24'h00_0000, $past(rd_byte)})
        else $error("read not answered in one cycle");
    a_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready)
        else $error("read ready held too long");
    a_rvalid_hold: assert property ((s_axi_rvalid && !s_axi_rready) |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");

    // ****************************************
    // divider checks
    // ****************************************
    a_reset_bypass: assert property ($rose(aresetn) |-> mode.bypass && div_power_down)
        else $error("not bypassed after reset");
    a_power_track: assert property (##1 div_power_down == $past(mode.bypass))
        else $error("power down does not follow bypass");
    a_bypass_idle: assert property (mode.bypass |=> st_reg == ODP_ST_IDLE)
        else $error("divider runs while bypassed");
    a_force_bypassed: assert property ((mode.bypass && mode.force_high &&
        mode.ignore_realign && !direct) |=> pair_a_first_out == $past(sel_level))
        else $error("force acted while bypassed");
    a_pair_equal: assert property (pair_a_second_out == pair_a_first_out)
        else $error("pair outputs differ");
    a_delay_step: assert property ((st_reg == ODP_ST_DELAY && tick && dly_reg != 4'h0 &&
        !accept && !mode.bypass) |=>
        st_reg == ODP_ST_DELAY && dly_reg == $past(dly_reg) - 4'h1)
        else $error("phase delay step wrong");
    a_delay_exit: assert property ((st_reg == ODP_ST_DELAY && tick && dly_reg == 4'h0 &&
        !accept && !mode.bypass) |=> st_reg == ODP_ST_RUN)
        else $error("phase delay not ended");
    a_run_step: assert property ((st_reg == ODP_ST_RUN && tick && !expire && !accept &&
        !mode.bypass) |=> cnt_reg == $past(cnt_reg) - 4'h1 && $stable(div_lvl_reg))
        else $error("divider count step wrong");
    a_run_hold: assert property ((st_reg == ODP_ST_RUN && !tick && !accept &&
        !mode.bypass) |=> $stable(cnt_reg) && $stable(div_lvl_reg))
        else $error("level changed between ticks");

endmodule : odp_top
`default_nettype wire

/* odp_top_test.sv */
// testbench: register access, routing, forcing and divider timing of the pair control
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e, m) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
    $display("wrong value at %0t: %s", $time, m); end end
module odp_top_test
    import odp_pkg::*;
;
    // ****************************************
    // stimulus and observed signals
    // ****************************************
    logic                  aclk          = 1'h0;
    logic                  aresetn       = 1'h0;
    logic [ODP_ADDR_W-1:0] s_axi_awaddr  = '0;
    logic [ODP_ADDR_W-1:0] s_axi_araddr  = '0;
    logic [31:0]           s_axi_wdata   = '0;
    logic [3:0]            s_axi_wstrb   = '0;
    logic                  s_axi_awvalid = 1'h0;
    logic                  s_axi_wvalid  = 1'h0;
    logic                  s_axi_bready  = 1'h0;
    logic                  s_axi_arvalid = 1'h0;
    logic                  s_axi_rready  = 1'h0;
    logic                  osc_level     = 1'h0;
    logic                  ext_level     = 1'h0;
    logic                  realign_req   = 1'h0;
    logic [1:0]            osc_cnt       = 2'h0;
    logic [31:0]           s_axi_rdata;
    logic [1:0]            s_axi_bresp, s_axi_rresp;
    logic                  s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic                  s_axi_arready, s_axi_rvalid;
    logic                  pair_a_first_out, pair_a_second_out;
    logic                  div_power_down, duty_fix_disable;
    logic                  osc_d, ext_d;
    int                    n_mismatch = 0;
    int                    n_tests    = 0;
    int                    cycles     = 0;

    odp_top uut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .osc_level(osc_level), .ext_level(ext_level),
        .realign_req(realign_req), .pair_a_first_out(pair_a_first_out),
        .pair_a_second_out(pair_a_second_out), .div_power_down(div_power_down),
        .duty_fix_disable(duty_fix_disable)
    );

    always #2 aclk = ~aclk;

    // ext toggles every cycle, osc every two: different rates expose a wrong selection
    always @(posedge aclk) begin
        ext_level <= ~ext_level;
        osc_cnt   <= osc_cnt + 2'h1;
        osc_level <= osc_cnt[1];
        ext_d     <= ext_level;
        osc_d     <= osc_level;
        cycles    <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            $display("wrong value at %0t: run timed out", $time);
            tally_and_finish();
        end
    end

    // ****************************************
    // bus tasks: handshakes judged and released at the same rising edge
    // ****************************************
    task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
        logic       pa, pw, pb, ha, hw, hb;
        logic [1:0] resp;
        pa = 1'h1;
        pw = 1'h1;
        pb = 1'h1;
        @(posedge aclk);
        s_axi_awaddr  <= {idx, 2'h0};
        s_axi_wdata   <= {24'h0, d};
        s_axi_wstrb   <= 4'hf;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        s_axi_bready  <= 1'h1;
        while (pa || pw || pb) begin
            @(posedge aclk);
            ha = s_axi_awvalid && s_axi_awready;
            hw = s_axi_wvalid && s_axi_wready;
            hb = s_axi_bvalid && s_axi_bready;
            if (hb) resp = s_axi_bresp;
            if (ha) s_axi_awvalid <= 1'h0;
            if (hw) s_axi_wvalid <= 1'h0;
            if (hb) s_axi_bready <= 1'h0;
            pa = pa && !ha;
            pw = pw && !hw;
            pb = pb && !hb;
        end
        `CHK(resp, er, "write response")
    endtask : wr

    task automatic rd(input logic [9:0] idx, input logic [7:0] ed, input logic [1:0] er);
        logic        pa, pr, ha, hr;
        logic [31:0] data;
        logic [1:0]  resp;
        pa = 1'h1;
        pr = 1'h1;
        @(posedge aclk);
        s_axi_araddr  <= {idx, 2'h0};
        s_axi_arvalid <= 1'h1;
        s_axi_rready  <= 1'h1;
        while (pa || pr) begin
            @(posedge aclk);
            ha = s_axi_arvalid && s_axi_arready;
            hr = s_axi_rvalid && s_axi_rready;
            if (hr) data = s_axi_rdata;
            if (hr) resp = s_axi_rresp;
            if (ha) s_axi_arvalid <= 1'h0;
            if (hr) s_axi_rready <= 1'h0;
            pa = pa && !ha;
            pr = pr && !hr;
        end
        `CHK(data, {24'h0, ed}, "read data")
        `CHK(resp, er, "read response")
    endtask : rd

    // sel 0 follows ext, 1 follows osc, 2 static low, 3 static high
    task automatic watch(input int sel, input int n);
        logic e;
        repeat (3) @(posedge aclk);
        repeat (n) begin
            @(negedge aclk);
            e = (sel == 0) ? ext_d : (sel == 1) ? osc_d : sel[0];
            `CHK(pair_a_first_out, e, "pair output level")
            `CHK(pair_a_second_out, pair_a_first_out, "pair outputs differ")
        end
    endtask : watch

    // one tick every two cycles, so a level of n+1 ticks lasts 2n+2 cycles
    task automatic runs(input int ehi, input int elo);
        int hi;
        int lo;
        hi = 0;
        lo = 0;
        @(negedge aclk);
        while (pair_a_first_out !== 1'h0) @(negedge aclk);
        while (pair_a_first_out !== 1'h1) @(negedge aclk);
        while (pair_a_first_out === 1'h1) begin
            hi++;
            @(negedge aclk);
        end
        while (pair_a_first_out === 1'h0) begin
            lo++;
            @(negedge aclk);
        end
        `CHK(hi, ehi, "high length")
        `CHK(lo, elo, "low length")
    endtask : runs

    // release realign at a fixed ext phase so two runs differ only by the offset
    task automatic phase_run(input logic [3:0] p, output int t);
        wr(ODP_IDX_MODE, {4'h0, p}, ODP_RESP_OKAY);
        @(posedge aclk);
        realign_req <= 1'h1;
        repeat (6) @(posedge aclk);
        @(negedge aclk);
        while (ext_level) @(negedge aclk);
        @(posedge aclk);
        realign_req <= 1'h0;
        t = 0;
        @(negedge aclk);
        while (pair_a_first_out !== 1'h1) begin
            t++;
            @(negedge aclk);
        end
    endtask : phase_run

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish

    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        int t0;
        int t3;
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        rd(ODP_IDX_MODE, 8'h80, ODP_RESP_OKAY);
        rd(ODP_IDX_ROUTING, 8'h00, ODP_RESP_OKAY);
        rd(ODP_IDX_COUNTS, 8'h00, ODP_RESP_OKAY);
        `CHK(div_power_down, 1'h1, "power down after reset")
        `CHK(duty_fix_disable, 1'h0, "duty fix after reset")
        rd(10'h100, 8'h00, ODP_RESP_SLVERR);
        wr(10'h100, 8'h5a, ODP_RESP_SLVERR);
        wr(ODP_IDX_STATUS, 8'h00, ODP_RESP_SLVERR);
        $display("test reset and map done");
        watch(0, 8);
        wr(ODP_IDX_MODE, 8'he0, ODP_RESP_OKAY);
        watch(0, 8);
        wr(ODP_IDX_SRCSEL, 8'h02, ODP_RESP_OKAY);
        watch(1, 8);
        $display("test bypass done");
        wr(ODP_IDX_MODE, 8'h60, ODP_RESP_OKAY);
        @(negedge aclk);
        `CHK(div_power_down, 1'h0, "divider powered")
        watch(3, 8);
        wr(ODP_IDX_ROUTING, 8'h02, ODP_RESP_OKAY);
        watch(1, 8);
        wr(ODP_IDX_SRCSEL, 8'h00, ODP_RESP_OKAY);
        watch(0, 8);
        wr(ODP_IDX_SRCSEL, 8'h01, ODP_RESP_OKAY);
        watch(3, 8);
        wr(ODP_IDX_MODE, 8'h20, ODP_RESP_OKAY);
        runs(2, 2);
        wr(ODP_IDX_ROUTING, 8'h00, ODP_RESP_OKAY);
        wr(ODP_IDX_SRCSEL, 8'h00, ODP_RESP_OKAY);
        wr(ODP_IDX_MODE, 8'h40, ODP_RESP_OKAY);
        watch(2, 8);
        wr(ODP_IDX_MODE, 8'h20, ODP_RESP_OKAY);
        runs(2, 2);
        $display("test routing and force done");
        wr(ODP_IDX_COUNTS, 8'h12, ODP_RESP_OKAY);
        wr(ODP_IDX_MODE, 8'h00, ODP_RESP_OKAY);
        runs(6, 4);
        wr(ODP_IDX_COUNTS, 8'hf0, ODP_RESP_OKAY);
        runs(2, 32);
        wr(ODP_IDX_COUNTS, 8'h00, ODP_RESP_OKAY);
        $display("test counts done");
        wr(ODP_IDX_MODE, 8'h10, ODP_RESP_OKAY);
        @(posedge aclk);
        realign_req <= 1'h1;
        watch(3, 12);
        wr(ODP_IDX_MODE, 8'h00, ODP_RESP_OKAY);
        watch(2, 12);
        wr(ODP_IDX_MODE, 8'h60, ODP_RESP_OKAY);
        watch(3, 12);
        @(posedge aclk);
        realign_req <= 1'h0;
        phase_run(4'h0, t0);
        phase_run(4'h3, t3);
        `CHK(t3 - t0, 6, "phase offset delay")
        rd(ODP_IDX_MODE, 8'h03, ODP_RESP_OKAY);
        $display("test realign and phase done");
        wr(ODP_IDX_ROUTING, 8'h01, ODP_RESP_OKAY);
        @(negedge aclk);
        `CHK(duty_fix_disable, 1'h1, "duty fix disable")
        rd(ODP_IDX_ROUTING, 8'h01, ODP_RESP_OKAY);
        $display("test duty fix done");
        tally_and_finish();
    end
endmodule : odp_top_test
`undef CHK
`default_nettype wire
